// *** verilog/ddr3_pin_front.sv ***
// Device-side pin front end: command capture, power states, data path
// Function
// - Sample control and address at CK rising crossing; strobe follows crossings.
// - Chip select high masks the command; low enables the decoder.
// - Command comes from registered RAS, CAS, WE with chip select.
// - Address carries row, column plus auto-precharge, or mode op-code.
// - Precharge one bank when address bit 10 low, all banks when high.
// - With on-the-fly chop enabled, bit 12 high means eight beats, low four.
// - Bank address picks the bank, or the mode register under LOAD MODE.
// - CKE low enters precharge power-down or self refresh, or active power-down.
// - CKE synchronous except self-refresh exit, which needs no clock edge.
// - Power-down keeps CK, CKE, reset, ODT; self refresh only CKE, reset.
// - Lower data mask high drops the lower byte of that write beat.
// - Upper data mask high drops the upper byte of that write beat.
// - Strobe edge-aligned with read data; controller centres it on writes.
// - On x8 with termination strobe enabled, masking is off.
// - ODT registered high applies termination only once enabled by LOAD MODE.
// - Active-low reset is asynchronous on assertion and release.
// - On x8 the no-function balls become termination strobe and DQ[7:4].
`timescale 1ns/100ps
module ddr3_pin_front #(
	parameter bit X16 = 1'b1
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic reset_n_i,
	input wire logic ck_t_i,
	input wire logic ck_c_i,
	input wire ddr3_pin_pkg::ca_t ca_i,
	input wire logic [ddr3_pin_pkg::DQ_W-1:0] dq_i,
	input wire logic dqs_i,
	input wire logic [1:0] dm_i,
	input wire logic [ddr3_pin_pkg::DQ_W-1:0] rd_data_i,
	input wire logic rd_valid_i,
	output logic [ddr3_pin_pkg::DQ_W-1:0] dq_o,
	output logic dq_oe_o,
	output logic dqs_t_o,
	output logic dqs_c_o,
	output logic dqs_oe_o,
	output logic tdqs_term_o,
	output logic term_on_o,
	output ddr3_pin_pkg::cmd_out_t cmd_o,
	output logic cmd_valid_o,
	output ddr3_pin_pkg::wr_beat_t wr_beat_o,
	output logic wr_valid_o,
	output logic [ddr3_pin_pkg::NBANK-1:0] bank_open_o,
	output ddr3_pin_pkg::pwr_t pwr_o,
	output ddr3_pin_pkg::buf_en_t buf_en_o
);
	import ddr3_pin_pkg::*;

	localparam int PIN_W = $bits(ca_t) + DQ_W + 4;
	localparam logic [PIN_W-1:0] PIN_RST =
		{CS_N_RST, 3'h7, CKE_RST, {(PIN_W - 5){1'b0}}};

	function automatic cmd_t decode(input ca_t c);
		if (c.cs_n) begin
			decode = CMD_DES;
		end else begin
			decode = cmd_t'({1'b0, c.ras_n, c.cas_n, c.we_n});
		end
	endfunction

	function automatic logic [NBANK-1:0] bank_bit(input logic [BANK_W-1:0] b);
		bank_bit = NBANK'(1) << b;
	endfunction

	// Pin inputs other than reset_n_i, all through two stages
	ca_t ca_s;
	logic [DQ_W-1:0] dq_s;
	logic ck_t_s;
	logic ck_c_s;
	logic dqs_s;
	logic [1:0] dm_s;

	pin_sync #(
		.W(PIN_W),
		.RST_VAL(PIN_RST)
	) u_sync (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i({ca_i, dq_i, ck_t_i, ck_c_i, dqs_i, dm_i[0]}),
		.q_o({ca_s, dq_s, ck_t_s, ck_c_s, dqs_s, dm_s[0]})
	);

	pin_sync #(
		.W(1),
		.RST_VAL(1'b0)
	) u_sync_udm (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.d_i(dm_i[1]),
		.q_o(dm_s[1])
	);

	// Edge finding and interface state
	logic ck_d;
	logic dqs_d;
	logic odt_reg;
	logic [3:0] wr_left;
	logic mr_wr;
	logic [BANK_W-1:0] mr_sel;
	logic [ADDR_W-1:0] mr_op;
	logic otf_en;
	logic term_en;
	logic tdqs_en;

	logic next_ck_d;
	logic next_dqs_d;
	logic next_odt_reg;
	logic [3:0] next_wr_left;
	logic next_mr_wr;
	logic [BANK_W-1:0] next_mr_sel;
	logic [ADDR_W-1:0] next_mr_op;
	logic [DQ_W-1:0] next_dq_o;
	logic next_dq_oe;
	logic next_dqs_t;
	logic next_dqs_oe;
	logic next_tdqs_term;
	logic next_term_on;
	cmd_out_t next_cmd;
	logic next_cmd_valid;
	wr_beat_t next_wr_beat;
	logic next_wr_valid;
	logic [NBANK-1:0] next_bank_open;
	pwr_t next_pwr;
	buf_en_t next_buf_en;

	logic ck_cross;
	logic ck_rise;
	logic ca_live;
	cmd_t cmd_now;
	logic chop_now;

	mode_regs u_mode (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.reset_n_i(reset_n_i),
		.wr_i(mr_wr),
		.sel_i(mr_sel),
		.op_i(mr_op),
		.otf_o(otf_en),
		.term_en_o(term_en),
		.tdqs_en_o(tdqs_en)
	);

	always_comb begin
		ck_cross = ck_t_s & ~ck_c_s;
		ck_rise = ck_cross & ~ck_d;
		// Decoder input buffers only live in normal operation
		ca_live = buf_en_o.ca;
		cmd_now = decode(ca_s);
		// Without on-the-fly, the fixed burst length stands at eight
		chop_now = otf_en & ~ca_s.addr[CHOP_BIT];

		next_ck_d = ck_cross;
		next_dqs_d = dqs_s;
		next_odt_reg = odt_reg;
		next_wr_left = wr_left;
		next_mr_wr = 1'b0;
		next_mr_sel = mr_sel;
		next_mr_op = mr_op;
		next_cmd = cmd_o;
		next_cmd_valid = 1'b0;
		next_bank_open = bank_open_o;
		next_pwr = pwr_o;
		next_wr_beat = wr_beat_o;
		next_wr_valid = 1'b0;
		next_dq_o = dq_o;
		next_dq_oe = dq_oe_o;
		next_dqs_t = dqs_t_o;
		next_dqs_oe = dqs_oe_o;

		// ODT keeps its buffer in power-down, not in self refresh
		if (ck_rise && buf_en_o.odt) begin
			next_odt_reg = ca_s.odt;
		end

		if (ck_rise && ca_live && ca_s.cke && cmd_now != CMD_DES) begin
			next_cmd.cmd = cmd_now;
			next_cmd.bank = ca_s.ba;
			next_cmd.addr = ca_s.addr;
			next_cmd.auto_pre = ca_s.addr[AP_BIT];
			next_cmd.chop = chop_now;
			next_cmd.pre_mask = '0;
			next_cmd_valid = cmd_now != CMD_NOP;
			case (cmd_now)
				CMD_ACT: begin
					next_bank_open = bank_open_o | bank_bit(ca_s.ba);
				end
				CMD_PRE: begin
					if (ca_s.addr[AP_BIT]) begin
						next_cmd.pre_mask = '1;
					end else begin
						next_cmd.pre_mask = bank_bit(ca_s.ba);
					end
					next_bank_open = bank_open_o & ~next_cmd.pre_mask;
				end
				CMD_WR, CMD_RD: begin
					// Auto-precharge closes the row at the command itself
					if (ca_s.addr[AP_BIT]) begin
						next_cmd.pre_mask = bank_bit(ca_s.ba);
						next_bank_open = bank_open_o & ~bank_bit(ca_s.ba);
					end
					if (cmd_now == CMD_WR) begin
						next_wr_left = chop_now ? BEATS_BC4 : BEATS_BL8;
					end
				end
				CMD_MRS: begin
					next_mr_wr = 1'b1;
					next_mr_sel = ca_s.ba;
					next_mr_op = ca_s.addr;
				end
				default: begin
				end
			endcase
		end

		case (pwr_o)
			PWR_ON: begin
				if (ck_rise && !ca_s.cke) begin
					if (!ca_s.cs_n && cmd_now == CMD_REF) begin
						next_pwr = PWR_SELF_REF;
					end else if (|bank_open_o) begin
						next_pwr = PWR_ACT_PD;
					end else begin
						next_pwr = PWR_PRE_PD;
					end
				end
			end
			PWR_PRE_PD, PWR_ACT_PD: begin
				if (ck_rise && ca_s.cke) begin
					next_pwr = PWR_ON;
				end
			end
			PWR_SELF_REF: begin
				// Clock may be stopped here, so no edge is awaited
				if (ca_s.cke) begin
					next_pwr = PWR_ON;
				end
			end
			default: begin
				next_pwr = PWR_ON;
			end
		endcase

		next_buf_en.ck = next_pwr != PWR_SELF_REF;
		next_buf_en.odt = next_pwr != PWR_SELF_REF;
		next_buf_en.ca = next_pwr == PWR_ON;
		next_buf_en.dq = next_pwr == PWR_ON;

		// Write beats land on either strobe edge, centred by the controller
		if (buf_en_o.dq && wr_left != 4'h0 && !dqs_oe_o && dqs_s != dqs_d) begin
			next_wr_beat.data = dq_s;
			if (X16) begin
				next_wr_beat.byte_en = ~dm_s;
			end else begin
				// DQ[7:4] sit on the former no-function balls
				next_wr_beat.data = {8'h00, dq_s[7:0]};
				next_wr_beat.byte_en = {1'b0, ~dm_s[0] | tdqs_en};
			end
			next_wr_valid = 1'b1;
			next_wr_left = wr_left - 4'h1;
		end

		// Read data and strobe leave together on each rising clock crossing
		if (ck_rise) begin
			next_dq_oe = rd_valid_i;
			next_dqs_oe = rd_valid_i;
			if (rd_valid_i) begin
				next_dq_o = X16 ? rd_data_i : {8'h00, rd_data_i[7:0]};
				next_dqs_t = ~dqs_t_o;
			end
		end

		next_term_on = term_en & odt_reg & buf_en_o.odt;
		next_tdqs_term = !X16 & tdqs_en & next_term_on;
	end

	// Pin reset clears all state but the synchronisers without waiting for a clock
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ck_d <= 1'b0;
			dqs_d <= 1'b0;
			odt_reg <= 1'b0;
			wr_left <= 4'h0;
			mr_wr <= 1'b0;
			mr_sel <= '0;
			mr_op <= '0;
			cmd_o <= '{cmd: CMD_DES, default: '0};
			cmd_valid_o <= 1'b0;
			wr_beat_o <= '0;
			wr_valid_o <= 1'b0;
			bank_open_o <= '0;
			pwr_o <= PWR_ON;
			buf_en_o <= '1;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			dqs_t_o <= 1'b0;
			dqs_c_o <= 1'b1;
			dqs_oe_o <= 1'b0;
			term_on_o <= 1'b0;
			tdqs_term_o <= 1'b0;
		end else if (srst_i) begin
			ck_d <= 1'b0;
			dqs_d <= 1'b0;
			odt_reg <= 1'b0;
			wr_left <= 4'h0;
			mr_wr <= 1'b0;
			mr_sel <= '0;
			mr_op <= '0;
			cmd_o <= '{cmd: CMD_DES, default: '0};
			cmd_valid_o <= 1'b0;
			wr_beat_o <= '0;
			wr_valid_o <= 1'b0;
			bank_open_o <= '0;
			pwr_o <= PWR_ON;
			buf_en_o <= '1;
			dq_o <= '0;
			dq_oe_o <= 1'b0;
			dqs_t_o <= 1'b0;
			dqs_c_o <= 1'b1;
			dqs_oe_o <= 1'b0;
			term_on_o <= 1'b0;
			tdqs_term_o <= 1'b0;
		end else begin
			ck_d <= next_ck_d;
			dqs_d <= next_dqs_d;
			odt_reg <= next_odt_reg;
			wr_left <= next_wr_left;
			mr_wr <= next_mr_wr;
			mr_sel <= next_mr_sel;
			mr_op <= next_mr_op;
			cmd_o <= next_cmd;
			cmd_valid_o <= next_cmd_valid;
			wr_beat_o <= next_wr_beat;
			wr_valid_o <= next_wr_valid;
			bank_open_o <= next_bank_open;
			pwr_o <= next_pwr;
			buf_en_o <= next_buf_en;
			dq_o <= next_dq_o;
			dq_oe_o <= next_dq_oe;
			dqs_t_o <= next_dqs_t;
			dqs_c_o <= ~next_dqs_t;
			dqs_oe_o <= next_dqs_oe;
			term_on_o <= next_term_on;
			tdqs_term_o <= next_tdqs_term;
		end
	end
endmodule

// *** include/ddr3_pin_pkg.sv ***
// Shared types and constants of the memory pin front end
package ddr3_pin_pkg;
	localparam int ADDR_W = 15;
	localparam int BANK_W = 3;
	localparam int NBANK = 8;
	localparam int DQ_W = 16;
	localparam int MR_N = 4;
	localparam int BURST_LONG = 8;
	localparam int BURST_SHORT = 4;
	localparam logic [3:0] BEATS_BL8 = 4'h8;
	localparam logic [3:0] BEATS_BC4 = 4'h4;
	// Address bit roles
	localparam int AP_BIT = 10;
	localparam int CHOP_BIT = 12;
	// Mode register fields
	localparam int MR0_BL_LSB = 0;
	localparam logic [1:0] MR0_BL_OTF = 2'h1;
	localparam int MR1_RTT0 = 2;
	localparam int MR1_RTT1 = 6;
	localparam int MR1_RTT2 = 9;
	localparam int MR1_TDQS = 11;
	localparam int MR2_RTTWR_LSB = 9;
	localparam logic [ADDR_W-1:0] MR_RST = 15'h0000;
	// Sync stage reset values
	localparam logic CS_N_RST = 1'b1;
	localparam logic CKE_RST = 1'b0;

	// Encoding of {cs_n, ras_n, cas_n, we_n}
	typedef enum logic [3:0] {
		CMD_MRS = 4'h0,
		CMD_REF = 4'h1,
		CMD_PRE = 4'h2,
		CMD_ACT = 4'h3,
		CMD_WR = 4'h4,
		CMD_RD = 4'h5,
		CMD_ZQ = 4'h6,
		CMD_NOP = 4'h7,
		CMD_DES = 4'h8
	} cmd_t;

	// Gray along normal, power-down, self refresh
	typedef enum logic [1:0] {
		PWR_ON = 2'h0,
		PWR_PRE_PD = 2'h1,
		PWR_ACT_PD = 2'h3,
		PWR_SELF_REF = 2'h2
	} pwr_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic odt;
		logic [BANK_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
	} ca_t;

	typedef struct packed {
		cmd_t cmd;
		logic [BANK_W-1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic auto_pre;
		logic chop;
		logic [NBANK-1:0] pre_mask;
	} cmd_out_t;

	typedef struct packed {
		logic [DQ_W-1:0] data;
		logic [1:0] byte_en;
	} wr_beat_t;

	typedef struct packed {
		logic ck;
		logic ca;
		logic odt;
		logic dq;
	} buf_en_t;
endpackage

// *** verilog/pin_sync.sv ***
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_q;

	always_comb begin
		next_meta = srst_i ? RST_VAL : d_i;
		next_q = srst_i ? RST_VAL : meta;
	end

	always_ff @(posedge clk_i) begin
		meta <= next_meta;
		q_o <= next_q;
	end
endmodule

// *** verilog/mode_regs.sv ***
// Four mode registers loaded by LOAD MODE, with decoded fields
`timescale 1ns/100ps
module mode_regs
	import ddr3_pin_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic reset_n_i,
	input wire logic wr_i,
	input wire logic [BANK_W-1:0] sel_i,
	input wire logic [ADDR_W-1:0] op_i,
	output logic otf_o,
	output logic term_en_o,
	output logic tdqs_en_o
);
	logic [MR_N-1:0][ADDR_W-1:0] mr;
	logic [MR_N-1:0][ADDR_W-1:0] next_mr;

	always_comb begin
		next_mr = mr;
		// Upper bank-select codes name no register and are dropped
		if (wr_i && sel_i < BANK_W'(MR_N)) begin
			next_mr[sel_i[1:0]] = op_i;
		end
		otf_o = mr[0][MR0_BL_LSB +: 2] == MR0_BL_OTF;
		term_en_o = mr[1][MR1_RTT0] | mr[1][MR1_RTT1] | mr[1][MR1_RTT2]
			| (|mr[2][MR2_RTTWR_LSB +: 2]);
		tdqs_en_o = mr[1][MR1_TDQS];
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mr <= {MR_N{MR_RST}};
		end else if (srst_i) begin
			mr <= {MR_N{MR_RST}};
		end else begin
			mr <= next_mr;
		end
	end
endmodule

// *** test/ddr3_pin_front_checker.sv ***
// Concurrent checks on the pin front end ports
`timescale 1ns/100ps
module ddr3_pin_front_checker (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic reset_n_i,
	input wire logic dqs_t_o,
	input wire logic dqs_c_o,
	input wire ddr3_pin_pkg::cmd_out_t cmd_o,
	input wire logic cmd_valid_o,
	input wire logic [ddr3_pin_pkg::NBANK-1:0] bank_open_o,
	input wire ddr3_pin_pkg::pwr_t pwr_o,
	input wire ddr3_pin_pkg::buf_en_t buf_en_o,
	input wire logic term_on_o
);
	import ddr3_pin_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i || !reset_n_i);
	dqs_pair_a: assert property (dqs_c_o == !dqs_t_o)
		else $error("strobe pair not complementary");
	cmd_pulse_a: assert property (cmd_valid_o |=> !cmd_valid_o)
		else $error("command pulse longer than one cycle");
	no_nop_a: assert property (cmd_valid_o |->
		!(cmd_o.cmd inside {CMD_NOP, CMD_DES}))
		else $error("idle code reported as command");
	pre_all_a: assert property (cmd_valid_o && cmd_o.cmd == CMD_PRE
		&& cmd_o.addr[AP_BIT] |-> cmd_o.pre_mask == 8'hff)
		else $error("precharge all mask wrong");
	pre_one_a: assert property (cmd_valid_o && cmd_o.cmd == CMD_PRE
		&& !cmd_o.addr[AP_BIT] |-> cmd_o.pre_mask == (8'h01 << cmd_o.bank))
		else $error("single bank precharge mask wrong");
	act_open_a: assert property (cmd_valid_o && cmd_o.cmd == CMD_ACT
		|-> ##[0:1] bank_open_o[cmd_o.bank])
		else $error("activated bank not open");
	pd_no_cmd_a: assert property (pwr_o != PWR_ON |=> !cmd_valid_o)
		else $error("command decoded while powered down");
	pd_bufs_a: assert property (pwr_o inside {PWR_PRE_PD, PWR_ACT_PD}
		|-> buf_en_o == 4'ha)
		else $error("power-down buffer enables wrong");
	sr_bufs_a: assert property (pwr_o == PWR_SELF_REF
		|-> buf_en_o == 4'h0)
		else $error("self refresh buffer enables wrong");
	sr_term_a: assert property ((pwr_o == PWR_SELF_REF) [*3]
		|-> !term_on_o)
		else $error("termination on in self refresh");
endmodule
bind ddr3_pin_front ddr3_pin_front_checker chk_u (.*);

// *** test/ddr3_ctrl_model.sv ***
// Controller-side pin model: link clock, command bus, write beats
`timescale 1ns/100ps
module ddr3_ctrl_model (
	input wire logic clk_i,
	input wire logic run_i,
	output logic ck_t_o,
	output logic ck_c_o,
	output ddr3_pin_pkg::ca_t ca_o,
	output logic [15:0] dq_o,
	output logic dqs_o,
	output logic [1:0] dm_o
);
	import ddr3_pin_pkg::*;
	initial begin
		ck_t_o = 1'b0;
		ca_o = {4'hf, 1'b1, 1'b0, 3'h0, 15'h0};
		dq_o = 16'h0;
		dqs_o = 1'b0;
		dm_o = 2'h0;
	end
	// Halted only to show that self-refresh exit needs no clock
	always #62.5 begin
		if (run_i) begin
			ck_t_o = ~ck_t_o;
		end
	end
	assign ck_c_o = ~ck_t_o;
	// Whole code word moves at once, half a period before the rise
	task automatic issue(logic [3:0] c, logic [2:0] ba, logic [14:0] a,
		logic cke);
		@(negedge ck_t_o);
		@(negedge clk_i);
		ca_o <= {c, cke, ca_o.odt, ba, a};
		@(negedge ck_t_o);
		@(negedge clk_i);
		ca_o <= {4'hf, cke, ca_o.odt, ~ba, ~a};
	endtask
	task automatic pins(logic cke, logic odt);
		@(negedge clk_i);
		ca_o.cke <= cke;
		ca_o.odt <= odt;
	endtask
	// Data settles well before the strobe edge, then goes stale
	task automatic beat(logic [15:0] d, logic [1:0] m);
		@(negedge clk_i);
		dq_o <= d;
		dm_o <= m;
		repeat (3) @(negedge clk_i);
		dqs_o <= ~dqs_o;
		repeat (3) @(negedge clk_i);
		dq_o <= ~d;
	endtask
endmodule

// *** test/ddr3_pin_front_test.sv ***
// Self-checking bench for the pin front end
`timescale 1ns/100ps
module ddr3_pin_front_test;
	import ddr3_pin_pkg::*;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic reset_n_i = 1'b1;
	logic run = 1'b1;
	logic rd_valid_i = 1'b0;
	logic [15:0] rd_data_i = 16'h0;
	int n_errors = 0;
	int compares = 0;
	ca_t ca;
	logic ck_t, ck_c, dqs, dq_oe_o, dqs_t_o, term_on_o, old;
	logic dqs_oe_o, tdqs_term_o, tdqs_term8;
	logic [15:0] dq8;
	wr_beat_t wr_beat8;
	logic cmd_valid_o, wr_valid_o;
	logic [15:0] dq, dq_o;
	logic [1:0] dm;
	logic [7:0] bank_open_o;
	cmd_out_t cmd_o;
	wr_beat_t wr_beat_o;
	pwr_t pwr_o;
	buf_en_t buf_en_o;
	always #5 clk_i = ~clk_i;
	ddr3_ctrl_model ctl_u (.clk_i(clk_i), .run_i(run), .ck_t_o(ck_t),
		.ck_c_o(ck_c), .ca_o(ca), .dq_o(dq), .dqs_o(dqs), .dm_o(dm));
	ddr3_pin_front dut_u (.clk_i(clk_i), .srst_i(srst_i),
		.reset_n_i(reset_n_i), .ck_t_i(ck_t), .ck_c_i(ck_c), .ca_i(ca),
		.dq_i(dq), .dqs_i(dqs), .dm_i(dm), .rd_data_i(rd_data_i),
		.rd_valid_i(rd_valid_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
		.dqs_t_o(dqs_t_o), .dqs_c_o(), .dqs_oe_o(dqs_oe_o),
		.tdqs_term_o(tdqs_term_o),
		.term_on_o(term_on_o), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o),
		.wr_beat_o(wr_beat_o), .wr_valid_o(wr_valid_o),
		.bank_open_o(bank_open_o), .pwr_o(pwr_o), .buf_en_o(buf_en_o));
	// Narrow build on the same pins, for the x8-only ball roles
	ddr3_pin_front #(.X16(1'b0)) dut8_u (.clk_i(clk_i), .srst_i(srst_i),
		.reset_n_i(reset_n_i), .ck_t_i(ck_t), .ck_c_i(ck_c), .ca_i(ca),
		.dq_i(dq), .dqs_i(dqs), .dm_i(dm), .rd_data_i(rd_data_i),
		.rd_valid_i(rd_valid_i), .dq_o(dq8), .dq_oe_o(),
		.dqs_t_o(), .dqs_c_o(), .dqs_oe_o(), .tdqs_term_o(tdqs_term8),
		.term_on_o(), .cmd_o(), .cmd_valid_o(),
		.wr_beat_o(wr_beat8), .wr_valid_o(),
		.bank_open_o(), .pwr_o(), .buf_en_o());
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		if (n_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic cmd(logic [3:0] c, logic [2:0] ba, logic [14:0] a,
		logic cke, logic exp);
		logic got;
		got = 1'b0;
		fork
			ctl_u.issue(c, ba, a, cke);
			repeat (40) begin
				@(negedge clk_i);
				if (cmd_valid_o === 1'b1)
					got = 1'b1;
			end
		join
		check("cmd_valid", got, exp);
	endtask
	task automatic wbeat(logic [15:0] d, logic [1:0] m, logic [1:0] en,
		logic exp);
		logic got;
		got = 1'b0;
		fork
			ctl_u.beat(d, m);
			repeat (12) begin
				@(negedge clk_i);
				if (wr_valid_o === 1'b1)
					got = 1'b1;
			end
		join
		check("wr_valid", got, exp);
		if (exp)
			check("byte_en", {wr_beat_o.byte_en, wr_beat_o.data}, {en, d});
	endtask
	task automatic ckwait;
		@(posedge ck_t);
		repeat (6) @(negedge clk_i);
	endtask
	initial begin
		#50000;
		n_errors++;
		final_report();
	end
	initial begin
		repeat (12) @(negedge clk_i);
		srst_i = 1'b0;
		check("pwr", pwr_o, PWR_ON);
		check("buf_en", buf_en_o, 4'hf);
		cmd(CMD_MRS, 3'h0, 15'h0001, 1'b1, 1'b1);
		cmd(CMD_MRS, 3'h1, 15'h0804, 1'b1, 1'b1);
		cmd(4'hb, 3'h5, 15'h0, 1'b1, 1'b0);
		cmd(CMD_ACT, 3'h3, 15'h1234, 1'b1, 1'b1);
		check("open", bank_open_o, 8'h08);
		cmd(CMD_WR, 3'h3, 15'h0010, 1'b1, 1'b1);
		check("chop", {cmd_o.cmd, cmd_o.bank, cmd_o.chop}, {CMD_WR, 4'h7});
		wbeat(16'h1234, 2'b01, 2'b10, 1'b1);
		check("x8_beat", {wr_beat8.byte_en, wr_beat8.data}, {2'b01, 16'h0034});
		wbeat(16'h5678, 2'b10, 2'b01, 1'b1);
		wbeat(16'h9abc, 2'b00, 2'b11, 1'b1);
		wbeat(16'hdef0, 2'b11, 2'b00, 1'b1);
		wbeat(16'h0f0f, 2'b00, 2'b11, 1'b0);
		cmd(CMD_WR, 3'h3, 15'h1000, 1'b1, 1'b1);
		check("bl8", cmd_o.chop, 1'b0);
		cmd(CMD_PRE, 3'h3, 15'h0, 1'b1, 1'b1);
		check("pre_one", cmd_o.pre_mask, 8'h08);
		cmd(CMD_PRE, 3'h0, 15'h0400, 1'b1, 1'b1);
		check("pre_all", cmd_o.pre_mask, 8'hff);
		// Start clear of any link edge still in the synchroniser
		ckwait();
		rd_data_i = 16'hbeef;
		rd_valid_i = 1'b1;
		old = dqs_t_o;
		ckwait();
		check("rd", {dq_o, dq_oe_o, dqs_oe_o, dqs_t_o}, {16'hbeef, 2'b11, ~old});
		check("rd_x8", dq8, 16'h00ef);
		rd_valid_i = 1'b0;
		ckwait();
		check("rd_end", dq_oe_o, 1'b0);
		ctl_u.pins(1'b1, 1'b1);
		ckwait();
		check("term", term_on_o, 1'b1);
		check("tdqs", {tdqs_term_o, tdqs_term8}, 2'b01);
		cmd(CMD_ACT, 3'h2, 15'h0, 1'b1, 1'b1);
		cmd(CMD_NOP, 3'h0, 15'h0, 1'b0, 1'b0);
		check("pwr", {pwr_o, buf_en_o}, {PWR_ACT_PD, 4'ha});
		cmd(CMD_NOP, 3'h0, 15'h0, 1'b1, 1'b0);
		check("pwr", pwr_o, PWR_ON);
		cmd(CMD_PRE, 3'h0, 15'h0400, 1'b1, 1'b1);
		cmd(CMD_NOP, 3'h0, 15'h0, 1'b0, 1'b0);
		check("pwr", {pwr_o, buf_en_o}, {PWR_PRE_PD, 4'ha});
		cmd(CMD_NOP, 3'h0, 15'h0, 1'b1, 1'b0);
		cmd(CMD_REF, 3'h0, 15'h0, 1'b0, 1'b0);
		check("pwr", {pwr_o, buf_en_o, term_on_o}, {PWR_SELF_REF, 5'h0});
		run = 1'b0;
		ctl_u.pins(1'b1, 1'b1);
		repeat (8) @(negedge clk_i);
		check("sr_exit", {pwr_o, buf_en_o}, {PWR_ON, 4'hf});
		run = 1'b1;
		cmd(CMD_MRS, 3'h1, 15'h0, 1'b1, 1'b1);
		ckwait();
		check("term_off", term_on_o, 1'b0);
		cmd(CMD_ACT, 3'h1, 15'h0, 1'b1, 1'b1);
		reset_n_i = 1'b0;
		#1;
		check("async_rst", {bank_open_o, pwr_o}, {8'h00, PWR_ON});
		#2;
		reset_n_i = 1'b1;
		cmd(CMD_ACT, 3'h6, 15'h0, 1'b1, 1'b1);
		check("open", bank_open_o, 8'h40);
		final_report();
	end
endmodule
